// [rtl/ddc_mode_cal.sv]
/*
 * Device-side mode register decode, latency timing, termination select and
 * calibration pattern reads, with an AXI4-Lite register window.
 * Assumes command pins and CK arrive asynchronously and CK is slower than CLK/4.
 */
// The AXI4-Lite register port and the address map were decided locally.
// Function
// - Read/write issued internally after additive latency
// - Read data after additive plus CAS latency
// - Additive latency codes: 0, CL-1, CL-2, reserved
// - Write data taken after AL plus CWL
// - CWL from second register bits 5:3
// - Output disable bit releases all outputs
// - Termination strobe terminates like data strobe
// - Bit 11 chooses data mask or termination
// - Second register selected by bank 010
// - Write termination from bits 10:9 during writes
// - No write termination while leveling
// - Third register selected by bank 011
// - Calibration off: reads go to array
// - Calibration on: reads redirected, precharge ignored
// - Lane bit 0 carries pattern, others copy/zero
// - Only column 2 and burst bits matter
// - Burst order by column bit 2
// - Location 00 returns alternating 0,1 pattern
`timescale 1ns/1ps
`include "ddc_defines.svh"
module ddc_mode_cal
    import ddc_pkg::*;
#(
    parameter int MAXD = 32
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // AXI4-Lite slave
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Memory link pins
    input wire logic CK,
    input wire logic CS_B,
    input wire logic RAS_B,
    input wire logic CAS_B,
    input wire logic WE_B,
    input wire logic [2:0] BA,
    input wire logic [15:0] A,
    input wire logic ODT,
    input wire logic DM_I,
    input wire logic [7:0] DQ_I,
    output logic [7:0] DQ_O,
    output logic DQ_OE_B,
    output logic DQS_O,
    output logic DQS_OE_B,
    // Termination
    output logic DQS_TERM_ON,
    output logic TERMINATION_STROBE_TERM_ON,
    output logic [2:0] RTT_CODE,
    output logic RTT_DYN,
    // Array side
    output logic RD_ISSUE,
    output logic WR_ISSUE,
    output logic [2:0] ARR_BANK,
    output logic [9:0] ARR_COL,
    input wire logic [63:0] ARRAY_RDATA,
    output logic WR_DONE,
    output logic [63:0] WR_DATA,
    output logic [7:0] WR_MASK
);
    logic [32:0] pin_s1, pin_s2;
    logic ck_s1, ck_s2, ck_s3, ck_rise, ck_edge;
    logic [15:0] a_s;
    logic [2:0] ba_s;
    logic [7:0] dq_s;
    logic dm_s, odt_s, cmd_ok, mrs_cmd, rd_cmd, wr_cmd;
    ddc_mr_t mr0_reg, mr1_reg, mr2_reg, mr3_reg;
    logic [31:0] ctrl_reg;
    logic [4:0] cl, al, cwl;
    logic [1:0] al_code, rtt_wr, mpr_loc;
    logic [2:0] rtt_nom;
    logic qoff, termination_strobe_en, wlvl, mpr_en, mpr_copy;

    // Pins and CK cross in through two flops before any use
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            ck_s1 <= 1'b0;
            ck_s2 <= 1'b0;
            ck_s3 <= 1'b0;
        end else begin
            pin_s1 <= {ODT, DM_I, DQ_I, CS_B, RAS_B, CAS_B, WE_B, BA, A};
            pin_s2 <= pin_s1;
            ck_s1 <= CK;
            ck_s2 <= ck_s1;
            ck_s3 <= ck_s2;
        end
    end

    assign ck_rise = ck_s2 & ~ck_s3;
    assign ck_edge = ck_s2 ^ ck_s3;
    assign a_s = pin_s2[15:0];
    assign ba_s = pin_s2[18:16];
    assign dq_s = pin_s2[30:23];
    assign dm_s = pin_s2[31];
    assign odt_s = pin_s2[32];
    assign cmd_ok = ck_rise & ctrl_reg[`DDC_CTRL_CMD_EN] & ~pin_s2[22];
    assign mrs_cmd = cmd_ok & ~pin_s2[21] & ~pin_s2[20] & ~pin_s2[19];
    assign rd_cmd = cmd_ok & pin_s2[21] & ~pin_s2[20] & pin_s2[19];
    // Writes are refused while calibration reads are on
    assign wr_cmd = cmd_ok & pin_s2[21] & ~pin_s2[20] & ~pin_s2[19] & ~mpr_en;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            mr0_reg <= `DDC_MR_RST;
            mr1_reg <= `DDC_MR_RST;
            mr2_reg <= `DDC_MR_RST;
            mr3_reg <= `DDC_MR_RST;
        end else if (mrs_cmd) begin
            unique case (ba_s)
                3'h0: mr0_reg <= a_s;
                3'h1: mr1_reg <= a_s;
                3'h2: mr2_reg <= a_s;
                3'h3: mr3_reg <= a_s;
                default: ;
            endcase
        end
    end

    assign qoff = mr1_reg[`DDC_MR1_QOFF];
    assign termination_strobe_en = mr1_reg[`DDC_MR1_TERMINATION_STROBE];
    assign wlvl = mr1_reg[`DDC_MR1_WLVL];
    assign al_code = mr1_reg[4:3];
    assign rtt_nom = {mr1_reg[9], mr1_reg[6], mr1_reg[2]};
    assign rtt_wr = mr2_reg[10:9];
    assign mpr_en = mr3_reg[`DDC_MR3_MPR];
    assign mpr_loc = mr3_reg[1:0];
    assign mpr_copy = ctrl_reg[`DDC_CTRL_MPR_COPY];
    assign cl = 5'(mr0_reg[6:4]) + `DDC_CL_BASE + (mr0_reg[2] ? `DDC_CL_EXT : 5'h0);
    assign cwl = 5'(mr2_reg[5:3]) + `DDC_CWL_BASE;

    always_comb begin
        unique case (al_code)
            2'b01: al = cl - 5'h1;
            2'b10: al = cl - 5'h2;
            default: al = 5'h0;
        endcase
    end

    // Read payload: chop, col2, calib, location, bank, column; write payload: chop, bank, column
    logic [17:0] rd_pl, rd_iss_d, rd_go_d;
    logic [13:0] wr_pl, wr_iss_d, wr_go_d;
    logic rd_iss_v, rd_go_v, wr_iss_v, wr_go_v;

    // Ignored address bits simply never enter the payload
    assign rd_pl = {~a_s[12], a_s[2], mpr_en, mpr_loc, ba_s, a_s[9:0]};
    assign wr_pl = {~a_s[12], ba_s, a_s[9:0]};

    ddc_lat_line #(.W(18), .MAXD(MAXD), .DW(5)) u_rd_al (
        .clk(CLK), .rst_b(RST_B), .en(ck_rise), .in_v(rd_cmd), .in_d(rd_pl),
        .dly(al), .out_v(rd_iss_v), .out_d(rd_iss_d));
    ddc_lat_line #(.W(18), .MAXD(MAXD), .DW(5)) u_rd_cl (
        .clk(CLK), .rst_b(RST_B), .en(ck_rise), .in_v(rd_iss_v), .in_d(rd_iss_d),
        .dly(cl), .out_v(rd_go_v), .out_d(rd_go_d));
    ddc_lat_line #(.W(14), .MAXD(MAXD), .DW(5)) u_wr_al (
        .clk(CLK), .rst_b(RST_B), .en(ck_rise), .in_v(wr_cmd), .in_d(wr_pl),
        .dly(al), .out_v(wr_iss_v), .out_d(wr_iss_d));
    ddc_lat_line #(.W(14), .MAXD(MAXD), .DW(5)) u_wr_cwl (
        .clk(CLK), .rst_b(RST_B), .en(ck_rise), .in_v(wr_iss_v), .in_d(wr_iss_d),
        .dly(cwl), .out_v(wr_go_v), .out_d(wr_go_d));

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            RD_ISSUE <= 1'b0;
            WR_ISSUE <= 1'b0;
            ARR_BANK <= 3'h0;
            ARR_COL <= 10'h000;
        end else begin
            RD_ISSUE <= rd_iss_v & ~rd_iss_d[15];
            WR_ISSUE <= wr_iss_v;
            if (rd_iss_v) begin
                ARR_BANK <= rd_iss_d[12:10];
                ARR_COL <= rd_iss_d[9:0];
            end else if (wr_iss_v) begin
                ARR_BANK <= wr_iss_d[12:10];
                ARR_COL <= wr_iss_d[9:0];
            end
        end
    end

    // Read burst: one beat per CK edge
    ddc_burst_t rd_st;
    logic [2:0] beat_reg, bcnt_reg;
    logic [17:0] rpl_reg;
    logic [7:0] dq_next;
    logic mbit, rd_run;

    assign rd_run = (rd_st == BS_RUN);

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rd_st <= BS_IDLE;
            beat_reg <= 3'h0;
            bcnt_reg <= 3'h0;
            rpl_reg <= '0;
        end else if (rd_go_v) begin
            rd_st <= BS_RUN;
            beat_reg <= {rd_go_d[16], 2'b00};
            bcnt_reg <= 3'h0;
            rpl_reg <= rd_go_d;
        end else if (rd_run && ck_edge) begin
            if (bcnt_reg == (rpl_reg[17] ? 3'h3 : 3'h7)) begin
                rd_st <= BS_IDLE;
            end else begin
                beat_reg <= beat_reg + 3'h1;
                bcnt_reg <= bcnt_reg + 3'h1;
            end
        end
    end

    always_comb begin
        mbit = (rpl_reg[14:13] == 2'b00) & beat_reg[0];
        if (!rpl_reg[15]) begin
            dq_next = ARRAY_RDATA[{beat_reg, 3'b000} +: 8];
        end else begin
            dq_next = {{7{mbit & mpr_copy}}, mbit};
        end
    end

    // Output disable wins over any burst in progress
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            DQ_O <= 8'h00;
            DQ_OE_B <= 1'b1;
            DQS_O <= 1'b0;
            DQS_OE_B <= 1'b1;
        end else begin
            DQ_O <= rd_run ? dq_next : 8'h00;
            DQ_OE_B <= ~rd_run | qoff;
            DQS_O <= rd_run & ~bcnt_reg[0];
            DQS_OE_B <= ~rd_run | qoff;
        end
    end

    // Write capture
    ddc_burst_t wr_st;
    logic [2:0] wcnt_reg, wnx;
    logic wbc4_reg, wr_run, wr_last;

    assign wr_run = (wr_st == BS_RUN);
    assign wnx = wcnt_reg + 3'h1;
    assign wr_last = wr_run & ck_edge & (wnx == (wbc4_reg ? 3'h3 : 3'h7));

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            wr_st <= BS_IDLE;
            wcnt_reg <= 3'h0;
            wbc4_reg <= 1'b0;
            WR_DATA <= 64'h0;
            WR_MASK <= 8'h00;
        end else if (wr_go_v) begin
            wr_st <= BS_RUN;
            wcnt_reg <= 3'h0;
            wbc4_reg <= wr_go_d[13];
            WR_DATA <= {56'h0, dq_s};
            WR_MASK <= {7'h00, dm_s & ~termination_strobe_en};
        end else if (wr_run && ck_edge) begin
            wcnt_reg <= wnx;
            WR_DATA[{wnx, 3'b000} +: 8] <= dq_s;
            WR_MASK[wnx] <= dm_s & ~termination_strobe_en;
            if (wr_last) begin
                wr_st <= BS_IDLE;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            WR_DONE <= 1'b0;
        end else begin
            WR_DONE <= wr_last;
        end
    end

    // Termination select; write value overrides nominal only outside leveling
    logic dyn;
    assign dyn = wr_run & (rtt_wr != 2'b00) & ~wlvl;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            RTT_CODE <= 3'h0;
            RTT_DYN <= 1'b0;
            DQS_TERM_ON <= 1'b0;
            TERMINATION_STROBE_TERM_ON <= 1'b0;
        end else begin
            RTT_CODE <= dyn ? {1'b0, rtt_wr} : rtt_nom;
            RTT_DYN <= odt_s & dyn;
            DQS_TERM_ON <= odt_s & (dyn | (rtt_nom != 3'h0));
            TERMINATION_STROBE_TERM_ON <= termination_strobe_en & odt_s & (dyn | (rtt_nom != 3'h0));
        end
    end

    // AXI4-Lite slave: address and data taken in either order
    logic aw_got, w_got;
    logic [7:0] waddr_reg, raddr;
    logic [31:0] wdata_reg, rd_data, stat;
    logic [3:0] wstrb_reg;
    logic [1:0] rd_resp;

    assign S_AXI_AWREADY = ~aw_got & ~S_AXI_BVALID;
    assign S_AXI_WREADY = ~w_got & ~S_AXI_BVALID;
    assign S_AXI_ARREADY = ~S_AXI_RVALID;
    assign raddr = S_AXI_ARADDR;
    assign stat = {3'h0, cwl, 3'h0, cl, 3'h0, al, wr_run, rd_run, wlvl, qoff,
                   termination_strobe_en, mpr_loc, mpr_en};

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            waddr_reg <= 8'h00;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `DDC_RESP_OK;
            ctrl_reg <= `DDC_CTRL_RST;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_got <= 1'b1;
                waddr_reg <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_got <= 1'b1;
                wdata_reg <= S_AXI_WDATA;
                wstrb_reg <= S_AXI_WSTRB;
            end
            if (aw_got && w_got) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= `DDC_RESP_OK;
                if (waddr_reg == `DDC_OFF_CTRL) begin
                    if (wstrb_reg[0]) begin
                        ctrl_reg[1:0] <= wdata_reg[1:0];
                    end
                end else if (waddr_reg != `DDC_OFF_STAT && waddr_reg != `DDC_OFF_MR0 &&
                             waddr_reg != `DDC_OFF_MR1 && waddr_reg != `DDC_OFF_MR2 &&
                             waddr_reg != `DDC_OFF_MR3) begin
                    S_AXI_BRESP <= `DDC_RESP_ERR;
                end
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    always_comb begin
        rd_resp = `DDC_RESP_OK;
        unique case (raddr)
            `DDC_OFF_CTRL: rd_data = ctrl_reg;
            `DDC_OFF_STAT: rd_data = stat;
            `DDC_OFF_MR0: rd_data = {16'h0, mr0_reg};
            `DDC_OFF_MR1: rd_data = {16'h0, mr1_reg};
            `DDC_OFF_MR2: rd_data = {16'h0, mr2_reg};
            `DDC_OFF_MR3: rd_data = {16'h0, mr3_reg};
            default: begin
                rd_data = 32'h0;
                rd_resp = `DDC_RESP_ERR;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0;
            S_AXI_RRESP <= `DDC_RESP_OK;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= rd_data;
            S_AXI_RRESP <= rd_resp;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // Helper: CK rises since the latest read, valid while one read is in flight
    logic [5:0] rl_cnt;
    logic [3:0] rd_pend;
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rl_cnt <= 6'h00;
            rd_pend <= 4'h0;
        end else begin
            if (rd_cmd) begin
                rl_cnt <= 6'h00;
            end else if (ck_rise && rl_cnt != 6'h3F) begin
                rl_cnt <= rl_cnt + 6'h01;
            end
            rd_pend <= rd_pend + 4'(rd_cmd) - 4'(rd_go_v);
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    sequence s_mrs3;
        mrs_cmd && ba_s == 3'h3;
    endsequence
    sequence s_mrs2;
        mrs_cmd && ba_s == 3'h2;
    endsequence

    chk_rl_sum: assert property (rd_go_v && rd_pend == 4'h1 && !rd_cmd |->
        rl_cnt == 6'(al) + 6'(cl) - 6'h01)
        else $error("read data start not at AL plus CL");
    chk_al_code: assert property (al_code == 2'b10 |-> al + 5'h2 == cl)
        else $error("additive latency CL-2 wrong");
    chk_mr2_load: assert property (s_mrs2 |=> mr2_reg == $past(a_s) &&
        cwl == 5'($past(a_s[5:3])) + 5'h5)
        else $error("second register not loaded");
    chk_mr3_load: assert property (s_mrs3 |=> mpr_en == $past(a_s[2]))
        else $error("third register not loaded");
    chk_qoff_all: assert property (qoff && $past(qoff) |-> DQ_OE_B && DQS_OE_B)
        else $error("outputs driven while disabled");
    chk_termination_strobe_term: assert property (TERMINATION_STROBE_TERM_ON |-> DQS_TERM_ON && $past(termination_strobe_en))
        else $error("termination strobe differs from data strobe");
    chk_dm_masked: assert property (WR_DONE && termination_strobe_en && $past(termination_strobe_en, 2) |->
        WR_MASK == 8'h00)
        else $error("mask taken while termination strobe on");
    chk_dyn_term: assert property (dyn && odt_s |=> RTT_DYN &&
        RTT_CODE == {1'b0, $past(rtt_wr)})
        else $error("write termination not applied");
    chk_wlvl_nom: assert property ($past(wlvl) |-> !RTT_DYN)
        else $error("write termination during leveling");
    chk_array_skip: assert property (rd_iss_v |=> RD_ISSUE == !$past(rd_iss_d[15]))
        else $error("array access not as calibration mode says");
    chk_lane_copy: assert property (!DQ_OE_B && rpl_reg[15] |->
        DQ_O[7:1] == 7'h00 || DQ_O[7:1] == {7{DQ_O[0]}})
        else $error("calibration lane bits wrong");
    chk_pattern_bit: assert property (rd_go_v && rd_go_d[15] && rd_go_d[14:13] == 2'b00
        |=> rd_run && beat_reg[1:0] == 2'b00 ##1 DQ_O[0] == 1'b0)
        else $error("calibration pattern must start at zero");
endmodule

// [rtl/ddc_defines.svh]
/*
 * Register offsets, field positions and reset values of the mode config block.
 * Included by the design files; holds definitions only.
 */
`ifndef DDC_DEFINES_SVH
`define DDC_DEFINES_SVH
`define DDC_OFF_CTRL 8'h00
`define DDC_OFF_STAT 8'h04
`define DDC_OFF_MR0 8'h08
`define DDC_OFF_MR1 8'h0C
`define DDC_OFF_MR2 8'h10
`define DDC_OFF_MR3 8'h14
`define DDC_CTRL_RST 32'h0000_0003
`define DDC_CTRL_CMD_EN 0
`define DDC_CTRL_MPR_COPY 1
`define DDC_MR_RST 16'h0000
`define DDC_MR1_QOFF 12
`define DDC_MR1_TERMINATION_STROBE 11
`define DDC_MR1_WLVL 7
`define DDC_MR3_MPR 2
`define DDC_CL_BASE 5'h4
`define DDC_CL_EXT 5'h8
`define DDC_CWL_BASE 5'h5
`define DDC_RESP_OK 2'h0
`define DDC_RESP_ERR 2'h2
`endif

// [rtl/ddc_pkg.sv]
/*
 * Types shared by the mode config block.
 * Assumes nothing of its surroundings.
 */
package ddc_pkg;
    typedef enum logic [1:0] {BS_IDLE = 2'b01, BS_RUN = 2'b10} ddc_burst_t;
    typedef logic [15:0] ddc_mr_t;
endpackage

// [rtl/ddc_lat_line.sv]
/*
 * Programmable latency line: a command with payload leaves after dly enable pulses.
 * Assumes en is the one-cycle CK rise pulse and in_v only rises with en.
 */
`timescale 1ns/1ps
module ddc_lat_line
    import ddc_pkg::*;
#(
    parameter int W = 8,
    parameter int MAXD = 32,
    parameter int DW = 5
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Command in
    input wire logic en,
    input wire logic in_v,
    input wire logic [W-1:0] in_d,
    input wire logic [DW-1:0] dly,
    // Command out
    output logic out_v,
    output logic [W-1:0] out_d
);
    logic [MAXD-1:0] v_reg;
    logic [W-1:0] d_reg [MAXD];
    logic [DW-1:0] tap;

    assign tap = dly - 1'b1;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            v_reg <= '0;
        end else if (en) begin
            v_reg <= {v_reg[MAXD-2:0], in_v};
        end
    end

    // Payload needs no reset; only the valid bits carry meaning
    always_ff @(posedge clk) begin
        if (en) begin
            d_reg[0] <= in_d;
            for (int k = 1; k < MAXD; k++) begin
                d_reg[k] <= d_reg[k-1];
            end
        end
    end

    always_comb begin
        if (dly == '0) begin
            out_v = en & in_v;
            out_d = in_d;
        end else begin
            out_v = en & v_reg[tap];
            out_d = d_reg[tap];
        end
    end

    chk_zero_passes: assert property (@(posedge clk) disable iff (!rst_b)
        en && in_v && dly == '0 |-> out_v && out_d == in_d)
        else $error("zero latency command not passed through");
endmodule

// [dv/ddc_ctl_model.sv]
/*
 * Controller-side model that drives the memory link pins.
 * Assumes CLK at 125 MHz; CK stands low between frames.
 */
`timescale 1ns/1ps
module ddc_ctl_model (
    // Clock
    input wire logic clk,
    // Link pins
    output logic ck,
    output logic cs_b,
    output logic ras_b,
    output logic cas_b,
    output logic we_b,
    output logic [2:0] ba,
    output logic [15:0] a,
    output logic [7:0] dq_i
);
    initial begin
        {ck, cs_b, ras_b, cas_b, we_b} = 5'h0F;
        ba = 3'h0;
        a = 16'h0000;
        dq_i = 8'h00;
    end
    // One 64 ns CK period; command pins held for the whole period, dq_i changes to d1 at CK fall
    task automatic cyc(input logic [3:0] c, input logic [2:0] b, input logic [15:0] ad,
                       input logic [7:0] d0, input logic [7:0] d1);
        @(posedge clk);
        {cs_b, ras_b, cas_b, we_b} <= c;
        ba <= b;
        a <= ad;
        dq_i <= d0;
        ck <= 1'b1;
        repeat (4) @(posedge clk);
        ck <= 1'b0;
        dq_i <= d1;
        repeat (3) @(posedge clk);
    endtask
    // Data lines toggle when not carrying write data, so stale bytes never match
    task automatic op(input logic [3:0] c, input logic [2:0] b, input logic [15:0] ad,
                      input int wl, input logic [63:0] dat, input int n);
        int k;
        cyc(c, b, ad, ~dq_i, dq_i);
        for (int i = 1; i < n; i++) begin
            k = i - wl;
            if (k >= 0 && k < 4) begin
                cyc(4'hF, 3'h0, 16'h0000, dat[16*k +: 8], dat[16*k+8 +: 8]);
            end else begin
                cyc(4'hF, 3'h0, 16'h0000, ~dq_i, dq_i);
            end
        end
    endtask
endmodule

// [dv/ddc_mode_cal_tb.sv]
/*
 * Self-checking bench for the mode config block.
 * Assumes the controller model above on the link and an AXI4-Lite master here.
 */
`timescale 1ns/1ps
`include "ddc_defines.svh"
module ddc_mode_cal_tb;
    logic CLK = 1'b0;
    logic RST_B = 1'b0;
    logic [7:0] S_AXI_AWADDR = 8'h00;
    logic [7:0] S_AXI_ARADDR = 8'h00;
    logic [31:0] S_AXI_WDATA = 32'h0;
    logic [3:0] S_AXI_WSTRB = 4'hF;
    logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
    logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0, ODT = 1'b0, DM_I = 1'b0;
    logic [63:0] ARRAY_RDATA = 64'h0;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    logic [31:0] S_AXI_RDATA;
    logic CK, CS_B, RAS_B, CAS_B, WE_B, DQ_OE_B, DQS_O, RD_ISSUE, WR_DONE, RTT_DYN;
    logic [2:0] BA;
    logic [15:0] A;
    logic [7:0] DQ_I, DQ_O, WR_MASK, wm;
    logic [63:0] WR_DATA, wd, d64;
    logic [31:0] d;
    logic [1:0] r;
    logic dqs_q = 1'b0, oe_q = 1'b1;
    logic [7:0] bq[$];
    int n_errors = 0, cmp_count = 0, cyc_n = 0, rc = 0, ri, lat, k, al, dn;

    ddc_mode_cal u_ddc_mode_cal (.CLK, .RST_B, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
        .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
        .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
        .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .CK, .CS_B, .RAS_B, .CAS_B, .WE_B, .BA,
        .A, .ODT, .DM_I, .DQ_I, .DQ_O, .DQ_OE_B, .DQS_O, .DQS_OE_B(), .DQS_TERM_ON(),
        .TERMINATION_STROBE_TERM_ON(), .RTT_CODE(), .RTT_DYN, .RD_ISSUE, .WR_ISSUE(), .ARR_BANK(),
        .ARR_COL(), .ARRAY_RDATA, .WR_DONE, .WR_DATA, .WR_MASK);
    ddc_ctl_model u_ddc_ctl_model (.clk(CLK), .ck(CK), .cs_b(CS_B), .ras_b(RAS_B),
        .cas_b(CAS_B), .we_b(WE_B), .ba(BA), .a(A), .dq_i(DQ_I));

    initial begin
        forever #4 CLK = ~CLK;
    end
    always @(posedge CK) rc <= rc + 1;
    // Beats are caught on each strobe change, independent of CK sync delay
    always @(posedge CLK) begin
        if (RD_ISSUE === 1'b1) ri = rc;
        if (DQ_OE_B === 1'b0 && oe_q === 1'b1) lat = rc;
        if (DQ_OE_B === 1'b0 && (DQS_O !== dqs_q || oe_q === 1'b1)) bq.push_back(DQ_O);
        if (WR_DONE === 1'b1) wd = WR_DATA;
        if (WR_DONE === 1'b1) wm = WR_MASK;
        if (RTT_DYN === 1'b1) dn = 1;
        dqs_q <= DQS_O;
        oe_q <= DQ_OE_B;
        cyc_n <= cyc_n + 1;
        if (cyc_n == 40000) begin
            n_errors++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("errors %0d checks %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic axw(input logic [7:0] ad, input logic [31:0] dw, output logic [1:0] rs);
        @(posedge CLK);
        S_AXI_AWADDR <= ad;
        S_AXI_WDATA <= dw;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        do begin
            @(posedge CLK);
            if (S_AXI_AWREADY === 1'b1) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY === 1'b1) S_AXI_WVALID <= 1'b0;
        end while (S_AXI_BVALID !== 1'b1);
        rs = S_AXI_BRESP;
        S_AXI_BREADY <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] ad, output logic [31:0] dr, output logic [1:0] rs);
        @(posedge CLK);
        S_AXI_ARADDR <= ad;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        do begin
            @(posedge CLK);
            if (S_AXI_ARREADY === 1'b1) S_AXI_ARVALID <= 1'b0;
        end while (S_AXI_RVALID !== 1'b1);
        dr = S_AXI_RDATA;
        rs = S_AXI_RRESP;
        S_AXI_RREADY <= 1'b0;
    endtask
    task automatic lk(input logic [3:0] c, input logic [2:0] b, input logic [15:0] ad,
                      input int wl, input logic [63:0] dw);
        bq.delete();
        ri = -1;
        lat = -1;
        dn = 0;
        rc = 0;
        u_ddc_ctl_model.op(c, b, ad, wl, dw, 14);
    endtask
    // Calibration beats: bit 0 alternates, upper bits copy it or stay zero
    task automatic beats(input int n, input bit cal, input bit cp);
        chk("beat_count", n, bq.size());
        for (int i = 0; i < n && i < bq.size(); i++) begin
            chk("dq", cal ? ((i % 2) ? (cp ? 8'hFF : 8'h01) : 8'h00) : ARRAY_RDATA[8*i +: 8],
                bq[i]);
        end
    endtask

    initial begin
        void'($urandom(33));
        repeat (16) @(posedge CLK);
        RST_B <= 1'b1;
        repeat (4) @(posedge CLK);
        axr(`DDC_OFF_CTRL, d, r);
        chk("ctrl", `DDC_CTRL_RST, d);
        axr(8'h40, d, r);
        chk("rresp", `DDC_RESP_ERR, r);
        for (k = 0; k < 3; k++) begin
            al = (k == 0) ? 0 : 4 - k;
            lk(4'h0, 3'h1, 16'(k << 3), 99, 64'h0);
            ARRAY_RDATA <= {$urandom, $urandom};
            lk(4'h5, 3'h0, 16'h1000, 99, 64'h0);
            chk("rd_issue", al + 1, ri);
            chk("rd_latency", al + 5, lat);
            beats(8, 0, 0);
        end
        for (k = 0; k < 2; k++) begin
            lk(4'h0, 3'h2, 16'(k << 3), 99, 64'h0);
            d64 = {$urandom, $urandom};
            lk(4'h4, 3'h0, 16'h1000, 7 + k, d64);
            chk("wr_data", d64, wd);
        end
        // Termination and mask: strobe share, plain mask, then leveling
        ODT <= 1'b1;
        DM_I <= 1'b1;
        lk(4'h0, 3'h2, 16'h0200, 99, 64'h0);
        for (k = 0; k < 3; k++) begin
            lk(4'h0, 3'h1, (k == 0) ? 16'h0800 : ((k == 1) ? 16'h0000 : 16'h0080), 99,
               64'h0);
            d64 = {$urandom, $urandom};
            lk(4'h4, 3'h0, 16'h1000, 5, d64);
            chk("wr_data_term", d64, wd);
            chk("wr_mask", (k == 0) ? 8'h00 : 8'hFF, wm);
            chk("rtt_dyn", k < 2, dn);
        end
        ODT <= 1'b0;
        DM_I <= 1'b0;
        lk(4'h0, 3'h1, 16'h1000, 99, 64'h0);
        lk(4'h5, 3'h0, 16'h1000, 99, 64'h0);
        chk("qoff_beats", 0, bq.size());
        lk(4'h0, 3'h1, 16'h0000, 99, 64'h0);
        lk(4'h0, 3'h3, 16'h0004, 99, 64'h0);
        for (k = 0; k < 3; k++) begin
            if (k == 2) axw(`DDC_OFF_CTRL, 32'h1, r);
            if (k == 2) chk("bresp", `DDC_RESP_OK, r);
            lk(4'h5, 3'h5, (k == 1) ? 16'h0404 : 16'h0400, 99, 64'h0);
            chk("cal_issue", -1, ri);
            chk("cal_latency", 5, lat);
            beats(4, 1, k < 2);
        end
        lk(4'h0, 3'h3, 16'h0000, 99, 64'h0);
        lk(4'h5, 3'h0, 16'h1000, 99, 64'h0);
        chk("rd_issue_back", 1, ri);
        beats(8, 0, 0);
        finish_test();
    end
endmodule
